//--- hw/sdpl_device.sv
// Synthesizer control end: serial word capture, dividers, power gating, lock detect
`timescale 1ns/1ps
`include "sdpl_regs.svh"
module sdpl_device (
  input wire logic CLK_I,
  input wire logic RST_I,
  sdpl_link_if.dev LINK,
  input wire logic CHIP_EN_I,
  input wire logic REF_TICK_I,
  input wire logic FB_TICK_I,
  input wire logic [3:0] PHASE_ERR_I,
  output logic RF_ACTIVE_O,
  output logic IF_ACTIVE_O,
  output logic LOCK_INDICATOR_O,
  output logic ACQ_WIDE_O,
  output logic [1:0] ACQ_LEVEL_O,
  output logic SPUR_TRACK_O,
  output logic SPUR_HOLD_O,
  output logic [7:0] RF_RATIO_INT_O,
  output logic [10:0] RF_FRAC_NUMERATOR_O,
  output logic RF_DIV_PULSE_O,
  output logic IF_DIV_PULSE_O,
  output logic IF_CMP_PULSE_O
);
  import sdpl_pkg::*;

  logic [2:0] clk_sync, data_sync, strobe_sync;
  logic clk_prev, strobe_prev, chip_en_meta, chip_en;
  sdpl_word_t shift;
  logic use_default, wide_variant, lock_out_select, ref_freq_select;
  logic rf_section_on, if_section_on;
  logic [1:0] if_variant, acq_bw_duration, acq_bw_level;
  logic acq_bw_on;
  sdpl_spur_t spur_scheme;
  logic [3:0] rf_program_count;
  logic [2:0] rf_swallow_count;
  logic [10:0] rf_frac_numerator;
  logic [8:0] if_prog, if_ref_user;
  logic [3:0] if_swallow;
  logic rf_run, if_run;
  logic [8:0] if_prog_eff, if_ref_eff;
  logic [3:0] if_swallow_eff;
  logic [13:0] if_ratio;
  logic [7:0] rf_ratio;
  logic [6:0] cmp_count;
  logic [2:0] good_run;
  logic locked, ever_locked;
  logic [9:0] acq_count;
  logic rf_pulse, if_pulse, cmp_pulse;

  // Link pins through two stages; third stage only for edge finding
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_sync <= 3'h0;
      data_sync <= 3'h0;
      strobe_sync <= 3'h0;
      chip_en_meta <= 1'b0;
      chip_en <= 1'b0;
    end else begin
      clk_sync <= {clk_sync[1:0], LINK.serial_clk};
      data_sync <= {data_sync[1:0], LINK.serial_data};
      strobe_sync <= {strobe_sync[1:0], LINK.latch_strobe};
      chip_en_meta <= CHIP_EN_I;
      chip_en <= chip_en_meta;
    end
  end
  assign clk_prev = clk_sync[2];
  assign strobe_prev = strobe_sync[2];

  // Shift register, MSB first on serial clock rise
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shift <= '0;
    end else if (clk_sync[1] && !clk_prev) begin
      shift <= {shift[`SDPL_WORD_W-2:0], data_sync[1]};
    end
  end

  // Control words loaded only on strobe rise
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      use_default <= 1'b1;
      wide_variant <= 1'b1;
      lock_out_select <= 1'b0;
      rf_program_count <= 4'h2;
      rf_swallow_count <= 3'h0;
      rf_frac_numerator <= 11'h000;
      if_variant <= 2'h2;
      ref_freq_select <= 1'b0;
      spur_scheme <= SDPL_SPUR_TRACK;
      rf_section_on <= 1'b0;
      if_section_on <= 1'b0;
      acq_bw_duration <= 2'h0;
      acq_bw_level <= 2'h0;
      acq_bw_on <= 1'b0;
      if_prog <= 9'h001;
      if_swallow <= 4'h0;
      if_ref_user <= 9'h002;
    end else if (strobe_sync[1] && !strobe_prev) begin
      // Trailing address bits form a prefix code; words 2 and 6 are ignored
      if (shift[1:0] == `SDPL_ADDR_WORD0) begin
        use_default <= shift[`SDPL_W0_DEFAULT_BIT];
        wide_variant <= shift[`SDPL_W0_RFSEL_BIT];
        lock_out_select <= shift[`SDPL_W0_LDSEL_BIT];
        rf_program_count <= shift[`SDPL_W0_B_HI:`SDPL_W0_B_LO];
        rf_swallow_count <= shift[`SDPL_W0_A_HI:`SDPL_W0_A_LO];
        rf_frac_numerator <= shift[`SDPL_W0_FN_HI:`SDPL_W0_FN_LO];
      end else if (shift[1:0] == `SDPL_ADDR_WORD1) begin
        if_variant <= shift[`SDPL_W1_IFSEL_HI:`SDPL_W1_IFSEL_LO];
        ref_freq_select <= shift[`SDPL_W1_REFSEL_BIT];
        spur_scheme <= sdpl_spur_t'(shift[`SDPL_W1_SPUR_HI:`SDPL_W1_SPUR_LO]);
        rf_section_on <= shift[`SDPL_W1_RFON_BIT];
        if_section_on <= shift[`SDPL_W1_IFON_BIT];
      end else if (shift[2:0] == `SDPL_ADDR_WORD3) begin
        acq_bw_duration <= shift[`SDPL_W3_DUR_HI:`SDPL_W3_DUR_LO];
        acq_bw_level <= shift[`SDPL_W3_LVL_HI:`SDPL_W3_LVL_LO];
        acq_bw_on <= shift[`SDPL_W3_ON_BIT];
      end else if (shift[3:0] == `SDPL_ADDR_WORD4) begin
        if_swallow <= shift[`SDPL_W4_A_HI:`SDPL_W4_A_LO];
        if_prog <= shift[`SDPL_W4_B_HI:`SDPL_W4_B_LO];
      end else if (shift[4:0] == `SDPL_ADDR_WORD5) begin
        if_ref_user <= shift[`SDPL_W5_R_HI:`SDPL_W5_R_LO];
      end
    end
  end

  // Power gating by pin and enable bits
  assign rf_run = chip_en && rf_section_on;
  assign if_run = chip_en && if_section_on;

  // Default or programmed IF counts
  always_comb begin
    if_ref_eff = ref_freq_select ? `SDPL_DEF_R_HIGH : `SDPL_DEF_R_LOW;
    unique case (if_variant)
      2'h0: begin
        if_prog_eff = `SDPL_DEF_B0;
        if_swallow_eff = `SDPL_DEF_A0;
      end
      2'h1: begin
        if_prog_eff = `SDPL_DEF_B1;
        if_swallow_eff = `SDPL_DEF_A1;
      end
      default: begin
        if_prog_eff = `SDPL_DEF_B2;
        if_swallow_eff = `SDPL_DEF_A2;
      end
    endcase
    if (!use_default) begin
      if_prog_eff = if_prog;
      if_swallow_eff = if_swallow;
      if_ref_eff = if_ref_user;
    end
  end

  // Integer division ratios
  assign if_ratio = 14'(`SDPL_IF_PRESC) * 14'(if_prog_eff) + 14'(if_swallow_eff);
  assign rf_ratio = (wide_variant ? 8'(`SDPL_PRESC_WIDE) : 8'(`SDPL_PRESC_NARROW)) * 8'(rf_program_count)
                  + 8'(rf_swallow_count);

  sdpl_divider #(.W(8)) u_rf_div (.clk_i(CLK_I), .rst_i(RST_I), .run_i(rf_run), .tick_i(FB_TICK_I),
    .ratio_i(rf_ratio), .pulse_o(rf_pulse));
  sdpl_divider #(.W(14)) u_if_div (.clk_i(CLK_I), .rst_i(RST_I), .run_i(if_run), .tick_i(FB_TICK_I),
    .ratio_i(if_ratio), .pulse_o(if_pulse));
  sdpl_divider #(.W(9)) u_if_ref (.clk_i(CLK_I), .rst_i(RST_I), .run_i(if_run), .tick_i(REF_TICK_I),
    .ratio_i(if_ref_eff), .pulse_o(cmp_pulse));

  // Lock filter: one compare per 64 reference cycles
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cmp_count <= 7'h0;
      good_run <= 3'h0;
      locked <= 1'b0;
    end else if (!rf_run) begin
      cmp_count <= 7'h0;
      good_run <= 3'h0;
      locked <= 1'b0;
    end else if (REF_TICK_I) begin
      cmp_count <= (cmp_count + 7'h1 >= `SDPL_CMP_EVERY) ? 7'h0 : cmp_count + 7'h1;
      if (cmp_count == 7'h0) begin
        if (PHASE_ERR_I > 4'(`SDPL_PHASE_CYC)) begin
          good_run <= 3'h0;
          locked <= 1'b0;
        end else begin
          good_run <= (good_run == `SDPL_LOCK_RUN) ? good_run : good_run + 3'h1;
          if (good_run + 3'h1 >= `SDPL_LOCK_RUN) begin
            locked <= 1'b1;
          end
        end
      end
    end
  end

  // Acquisition widening and spur hold after first lock
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      acq_count <= 10'h0;
      ever_locked <= 1'b0;
    end else if (!rf_run) begin
      acq_count <= 10'h0;
      ever_locked <= 1'b0;
    end else begin
      if (locked) begin
        ever_locked <= 1'b1;
      end
      if (!locked && acq_count < {acq_bw_duration, `SDPL_BW_UNIT}) begin
        acq_count <= acq_count + 10'h1;
      end else if (locked) begin
        acq_count <= 10'h0;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      RF_ACTIVE_O <= 1'b0;
      IF_ACTIVE_O <= 1'b0;
      LOCK_INDICATOR_O <= 1'b0;
      ACQ_WIDE_O <= 1'b0;
      ACQ_LEVEL_O <= 2'h0;
      SPUR_TRACK_O <= 1'b0;
      SPUR_HOLD_O <= 1'b0;
      RF_RATIO_INT_O <= 8'h0;
      RF_FRAC_NUMERATOR_O <= 11'h0;
      RF_DIV_PULSE_O <= 1'b0;
      IF_DIV_PULSE_O <= 1'b0;
      IF_CMP_PULSE_O <= 1'b0;
    end else begin
      RF_ACTIVE_O <= rf_run;
      IF_ACTIVE_O <= if_run;
      LOCK_INDICATOR_O <= lock_out_select && locked;
      ACQ_WIDE_O <= rf_run && acq_bw_on && !locked && (acq_count < {acq_bw_duration, `SDPL_BW_UNIT});
      ACQ_LEVEL_O <= acq_bw_level;
      SPUR_TRACK_O <= rf_run && (spur_scheme == SDPL_SPUR_TRACK);
      SPUR_HOLD_O <= rf_run && (spur_scheme == SDPL_SPUR_ONCE) && ever_locked;
      RF_RATIO_INT_O <= rf_ratio;
      RF_FRAC_NUMERATOR_O <= rf_frac_numerator;
      RF_DIV_PULSE_O <= rf_pulse;
      IF_DIV_PULSE_O <= if_pulse;
      IF_CMP_PULSE_O <= cmp_pulse;
    end
  end
endmodule

//--- hw/sdpl_divider.sv
// Loadable modulus counter giving one pulse every ratio input cycles
`timescale 1ns/1ps
module sdpl_divider #(
  parameter int W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic tick_i,
  input wire logic [W-1:0] ratio_i,
  output logic pulse_o
);
  logic [W-1:0] count;

  // Count input ticks, wrap at ratio
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count <= '0;
      pulse_o <= 1'b0;
    end else if (!run_i) begin
      count <= '0;
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= 1'b0;
      if (tick_i) begin
        if (count + W'(1) >= ratio_i) begin
          count <= '0;
          pulse_o <= 1'b1;
        end else begin
          count <= count + W'(1);
        end
      end
    end
  end
endmodule

//--- hw/sdpl_host.sv
// Host end: shifts one 24-bit control word out, MSB first, then pulses the strobe
`timescale 1ns/1ps
`include "sdpl_regs.svh"
module sdpl_host (
  input wire logic CLK_I,
  input wire logic RST_I,
  sdpl_link_if.host LINK,
  input wire logic SEND_I,
  input wire logic [23:0] WORD_I,
  input wire logic POWERED_DOWN_I,
  output logic BUSY_O,
  output logic DONE_O
);
  import sdpl_pkg::*;

  typedef enum logic [1:0] {SDPL_IDLE, SDPL_SHIFT, SDPL_STROBE} sdpl_hstate_t;
  sdpl_hstate_t state;
  sdpl_word_t word;
  logic [4:0] bits;
  logic [3:0] div;
  logic phase;

  // Serial clock from divider; data changes on falling phase
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state <= SDPL_IDLE;
      word <= '0;
      bits <= 5'h0;
      div <= 4'h0;
      phase <= 1'b0;
      LINK.serial_clk <= 1'b0;
      LINK.serial_data <= 1'b0;
      LINK.latch_strobe <= 1'b0;
      BUSY_O <= 1'b0;
      DONE_O <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      div <= (div + 4'h1 >= `SDPL_HOST_DIV) ? 4'h0 : div + 4'h1;
      unique case (state)
        SDPL_IDLE: begin
          LINK.serial_clk <= 1'b0;
          LINK.latch_strobe <= 1'b0;
          LINK.serial_data <= 1'b0;
          if (SEND_I && !POWERED_DOWN_I) begin
            word <= WORD_I;
            bits <= 5'h0;
            phase <= 1'b0;
            BUSY_O <= 1'b1;
            state <= SDPL_SHIFT;
          end
        end
        SDPL_SHIFT: begin
          if (div == 4'h0) begin
            phase <= !phase;
            if (!phase) begin
              LINK.serial_clk <= 1'b0;
              LINK.serial_data <= word[`SDPL_WORD_W-1];
              word <= {word[`SDPL_WORD_W-2:0], 1'b0};
            end else begin
              LINK.serial_clk <= 1'b1;
              bits <= bits + 5'h1;
              if (bits + 5'h1 == 5'(`SDPL_WORD_W)) begin
                state <= SDPL_STROBE;
              end
            end
          end
        end
        SDPL_STROBE: begin
          if (div == 4'h0) begin
            if (LINK.serial_clk) begin
              LINK.serial_clk <= 1'b0;
            end else if (!LINK.latch_strobe) begin
              LINK.latch_strobe <= 1'b1;
            end else begin
              LINK.latch_strobe <= 1'b0;
              LINK.serial_data <= 1'b0;
              BUSY_O <= 1'b0;
              DONE_O <= 1'b1;
              state <= SDPL_IDLE;
            end
          end
        end
        default: state <= SDPL_IDLE;
      endcase
    end
  end
endmodule

//--- hw/sdpl_link_if.sv
// Three-wire serial programming link between host and synthesizer
`timescale 1ns/1ps
interface sdpl_link_if;
  logic serial_clk;
  logic serial_data;
  logic latch_strobe;
  modport host (output serial_clk, output serial_data, output latch_strobe);
  modport dev (input serial_clk, input serial_data, input latch_strobe);
endinterface

//--- hw/sdpl_pkg.sv
// Types shared by both ends of the synthesizer programming link
package sdpl_pkg;
  typedef enum logic [1:0] {SDPL_SPUR_OFF, SDPL_SPUR_UNUSED, SDPL_SPUR_TRACK, SDPL_SPUR_ONCE} sdpl_spur_t;
  typedef logic [23:0] sdpl_word_t;
endpackage

//--- hw/sdpl_regs.svh
// Field positions, addresses, defaults and timing counts of the synthesizer control block
`ifndef SDPL_REGS_SVH
`define SDPL_REGS_SVH
`define SDPL_WORD_W 24
`define SDPL_ADDR_WORD0 2'h0
`define SDPL_ADDR_WORD1 2'h1
`define SDPL_ADDR_WORD3 3'h3
`define SDPL_ADDR_WORD4 4'h7
`define SDPL_ADDR_WORD5 5'h0F
`define SDPL_W3_DUR_HI 23
`define SDPL_W3_DUR_LO 22
`define SDPL_W3_LVL_HI 21
`define SDPL_W3_LVL_LO 20
`define SDPL_W3_ON_BIT 19
`define SDPL_W0_DEFAULT_BIT 23
`define SDPL_W0_RFSEL_BIT 22
`define SDPL_W0_LDSEL_BIT 21
`define SDPL_W0_B_HI 19
`define SDPL_W0_B_LO 16
`define SDPL_W0_A_HI 15
`define SDPL_W0_A_LO 13
`define SDPL_W0_FN_HI 12
`define SDPL_W0_FN_LO 2
`define SDPL_W1_IFSEL_HI 23
`define SDPL_W1_IFSEL_LO 22
`define SDPL_W1_REFSEL_BIT 21
`define SDPL_W1_SPUR_HI 12
`define SDPL_W1_SPUR_LO 11
`define SDPL_W1_RFON_BIT 3
`define SDPL_W1_IFON_BIT 2
`define SDPL_W4_A_HI 16
`define SDPL_W4_A_LO 13
`define SDPL_W4_B_HI 12
`define SDPL_W4_B_LO 4
`define SDPL_W5_R_HI 13
`define SDPL_W5_R_LO 5
`define SDPL_PRESC_WIDE 4'h8
`define SDPL_PRESC_NARROW 4'h6
`define SDPL_IF_PRESC 5'h10
`define SDPL_DEF_B0 9'h058
`define SDPL_DEF_A0 4'hF
`define SDPL_DEF_B1 9'h0BF
`define SDPL_DEF_A1 4'h4
`define SDPL_DEF_B2 9'h0E5
`define SDPL_DEF_A2 4'h9
`define SDPL_DEF_R_LOW 9'h0A0
`define SDPL_DEF_R_HIGH 9'h0A4
`define SDPL_CMP_EVERY 7'h40
`define SDPL_LOCK_RUN 3'h4
`define SDPL_PHASE_NS 10
`define SDPL_CLK_NS 20
`define SDPL_PHASE_CYC ((`SDPL_PHASE_NS + `SDPL_CLK_NS - 1) / `SDPL_CLK_NS)
`define SDPL_BW_UNIT 8'h40
`define SDPL_HOST_DIV 4'h4
`endif

//--- tb/sdpl_chk.sv
// Wire-level checker for the three-wire programming link
`timescale 1ns/1ps
module sdpl_chk (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic serial_clk,
  input wire logic serial_data,
  input wire logic latch_strobe
);
  logic clk_q;
  logic [5:0] rises;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // Counts link clock rises since the last strobe
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      clk_q <= 1'b0;
      rises <= 6'h00;
    end else begin
      clk_q <= serial_clk;
      if (latch_strobe) begin
        rises <= 6'h00;
      end else if (serial_clk && !clk_q) begin
        rises <= rises + 6'h01;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_data_held_high: assert property (serial_clk |-> $stable(serial_data))
    else $error("data moved while link clock high");
  a_data_setup: assert property ($rose(serial_clk) |-> serial_data == $past(serial_data, 3))
    else $error("data not set up before link clock rise");
  a_clk_high_width: assert property ($rose(serial_clk) |-> serial_clk [*4] ##1 !serial_clk)
    else $error("link clock high time wrong");
  a_clk_low_width: assert property ($fell(serial_clk) |-> !serial_clk [*4])
    else $error("link clock low time too short");
  a_strobe_width: assert property ($rose(latch_strobe) |-> latch_strobe [*4] ##1 !latch_strobe)
    else $error("strobe width wrong");
  a_strobe_no_clk: assert property (latch_strobe |-> !serial_clk)
    else $error("link clock high during strobe");
  a_word_length: assert property ($rose(latch_strobe) |-> rises == 6'h18)
    else $error("strobe not after exactly 24 bits");
  a_clk_to_strobe: assert property ($rose(latch_strobe) |-> !$past(serial_clk) && !$past(serial_clk, 3))
    else $error("strobe too close to link clock");
  a_frame_moves: assert property ($rose(serial_clk) |-> ##[1:12] ($rose(serial_clk) || $rose(latch_strobe)))
    else $error("frame stalled");

  c_word_latched: cover property ($rose(latch_strobe));
  c_bit_shifted: cover property ($rose(serial_clk));
  c_strobe_done: cover property ($fell(latch_strobe));
endmodule

//--- tb/test_synth_divider_powerdown_lockdetect.sv
// Bench joining host and device ends over the programming link
`timescale 1ns/1ps
module test_synth_divider_powerdown_lockdetect;
  logic clk = 1'b0;
  logic rst, go, pdn, busy, done, ce, rtk, sc_q;
  logic rfa, ifa, lk, strk, acqw, shold, rfd, ifd;
  logic [1:0] alvl;
  logic [3:0] err;
  logic [7:0] ratio;
  logic [10:0] frac;
  logic icp;
  logic [23:0] word, cap;
  int ncap, ncmp, nrf, ndiv, n_errors, checks, k;

  // ----------------------------------------
  // Structure
  // ----------------------------------------
  sdpl_link_if link ();
  sdpl_host u_sdpl_host (.CLK_I(clk), .RST_I(rst), .LINK(link), .SEND_I(go), .WORD_I(word),
    .POWERED_DOWN_I(pdn), .BUSY_O(busy), .DONE_O(done));
  sdpl_device u_sdpl_device (.CLK_I(clk), .RST_I(rst), .LINK(link), .CHIP_EN_I(ce), .REF_TICK_I(rtk),
    .FB_TICK_I(rtk), .PHASE_ERR_I(err), .RF_ACTIVE_O(rfa), .IF_ACTIVE_O(ifa), .LOCK_INDICATOR_O(lk),
    .ACQ_WIDE_O(acqw), .ACQ_LEVEL_O(alvl), .SPUR_TRACK_O(strk), .SPUR_HOLD_O(shold), .RF_RATIO_INT_O(ratio),
    .RF_FRAC_NUMERATOR_O(frac), .RF_DIV_PULSE_O(rfd), .IF_DIV_PULSE_O(ifd), .IF_CMP_PULSE_O(icp));
  sdpl_chk u_sdpl_chk (.CLK_I(clk), .RST_I(rst), .serial_clk(link.serial_clk),
    .serial_data(link.serial_data), .latch_strobe(link.latch_strobe));

  // Clock source
  always #10 clk = ~clk;

  // Wire capture and compare pulse count
  always @(posedge clk) begin
    sc_q <= link.serial_clk;
    if (link.serial_clk && !sc_q) begin
      cap <= {cap[22:0], link.serial_data};
      ncap <= ncap + 1;
    end
    if (icp) ncmp <= ncmp + 1;
    if (rfd) nrf <= nrf + 1;
    if (ifd) ndiv <= ndiv + 1;
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [23:0] w0(logic d, logic s, logic l, logic [3:0] b, logic [2:0] a, logic [10:0] f);
    return {d, s, l, 1'b0, b, a, f, 2'b00};
  endfunction

  function automatic logic [23:0] w1(logic [1:0] sp, logic rf, logic fi);
    return {2'b10, 9'h000, sp, 7'h00, rf, fi, 2'b01};
  endfunction

  // Sends one word and compares what crossed the wire
  task automatic send(input logic [23:0] w);
    logic [7:0] r0;
    logic s, bad;
    int i;
    r0 = ratio;
    s = 1'b0;
    bad = 1'b0;
    ncap = 0;
    word = w;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    for (i = 0; i < 400 && !done; i++) begin
      @(negedge clk);
      s |= link.latch_strobe;
      bad |= !s && (ratio !== r0);
    end
    chk(bad, 0);
    chk({done, cap}, {1'b1, w});
    chk(ncap, 24);
    repeat (8) @(negedge clk);
  endtask

  task automatic ticks(input int n, input logic [3:0] e);
    repeat (n) begin
      rtk = 1'b1;
      err = e;
      @(negedge clk);
      rtk = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask

  task automatic test_done();
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    go = 1'b0;
    pdn = 1'b1;
    ce = 1'b1;
    rtk = 1'b0;
    err = 4'h0;
    word = 24'h000000;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    chk({rfa, ifa, lk, ratio}, 0);
    word = 24'hFFFFF8;
    go = 1'b1;
    @(negedge clk);
    go = 1'b0;
    repeat (12) begin
      @(negedge clk);
      chk({busy, link.serial_clk, link.serial_data, link.latch_strobe}, 0);
    end
    pdn = 1'b0;
    send(w0(1'b0, 1'b1, 1'b1, 4'hF, 3'h7, 11'h77E));
    chk({ratio, frac}, {8'h7F, 11'h77E});
    send(w0(1'b0, 1'b0, 1'b1, 4'h2, 3'h1, 11'h002));
    chk(ratio, 8'h0D);
    send(24'hFFFFF6);
    chk(ratio, 8'h0D);
    for (k = 0; k < 4; k++) begin
      send(w1(2'b10, k[1], k[0]));
      chk({rfa, ifa}, k);
    end
    send({2'h1, 2'h2, 1'b1, 16'h0000, 3'h3});
    ce = 1'b0;
    repeat (6) @(negedge clk);
    chk({rfa, ifa}, 0);
    ce = 1'b1;
    repeat (6) @(negedge clk);
    chk({acqw, alvl}, 3'h6);
    send(w1(2'b00, 1'b1, 1'b1));
    chk(strk, 0);
    send(w1(2'b11, 1'b1, 1'b1));
    chk({strk, shold}, 0);
    send(w1(2'b10, 1'b1, 1'b1));
    chk(strk, 1);
    chk(acqw, 0);
    ticks(190, 4'h0);
    chk(lk, 0);
    ticks(130, 4'h0);
    chk(lk, 1);
    ticks(70, 4'h3);
    chk(lk, 0);
    ticks(320, 4'h0);
    chk(lk, 1);
    send(w1(2'b11, 1'b1, 1'b1));
    chk(shold, 1);
    send(w0(1'b1, 1'b0, 1'b0, 4'h2, 3'h1, 11'h002));
    chk(lk, 0);
    ticks(10, 4'h0);
    ncmp = 0;
    ticks(320, 4'h0);
    chk(ncmp, 2);
    send({10'h000, 9'h005, 5'h0F});
    send({7'h00, 4'h1, 9'h002, 4'h7});
    send(w0(1'b0, 1'b0, 1'b0, 4'h2, 3'h1, 11'h002));
    ce = 1'b0;
    repeat (6) @(negedge clk);
    ce = 1'b1;
    repeat (6) @(negedge clk);
    ncmp = 0;
    nrf = 0;
    ndiv = 0;
    ticks(66, 4'h0);
    chk(ncmp, 13);
    chk(ndiv, 2);
    chk(nrf, 5);
    test_done();
  end

  // Watchdog
  initial begin
    #1000000;
    n_errors++;
    test_done();
  end
endmodule
